/* File: hdl/lpbr_unit.sv */
// Low-power sequencer, break flag protection and reset cause registers.
`timescale 1ns/1ps
module lpbr_unit
(
	input  wire logic                   mclk,
	input  wire logic                   rstn,
	input  wire logic                   crystal_clock,
	// Core events.
	input  wire logic                   wait_exec,
	input  wire logic                   stop_exec,
	input  wire logic                   irq_pending,
	input  wire logic                   break_irq,
	input  wire logic                   reset_req,
	input  wire lpbr_pkg::reset_cause_s reset_src,
	input  wire logic                   opcode_fetch,
	input  wire logic                   break_active,
	input  wire logic                   watchdog_disable,
	input  wire logic                   short_recovery_sel,
	// Peripheral flag clear request.
	input  wire logic                   flag_clear_req,
	output logic                        flag_clear_allow,
	output logic                        clear_i_mask,
	output logic                        stack_go,
	output logic                        break_regs_hold,
	output lpbr_pkg::clk_gate_s         clk_gate,
	// AXI4-Lite slave.
	input  wire logic [3:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [3:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	lpbr_pkg::mode_e        mode;          // Power mode.
	lpbr_pkg::reset_cause_s cause;         // Last reset cause.
	logic                   break_wait;    // Break ended wait.
	logic                   clr_en;        // Break clear enable.
	logic                   rec_done;      // Recovery counter done.
	logic                   rec_done_s1;   // Synchroniser stage one.
	logic                   rec_done_s2;   // Synchroniser stage two.
	logic                   hold_clear;    // Counter hold in stop.
	logic                   aw_held;       // Write address captured.
	logic [3:0]             aw_addr;       // Captured write address.
	logic                   w_held;        // Write data captured.
	logic [31:0]            w_data;        // Captured write data.
	logic [3:0]             w_strb;        // Captured strobes.
	logic                   wr_fire;       // Write commits now.
	logic                   rd_fire;       // Read taken now.
	logic [7:0]             rd_byte;       // Selected read value.

	// Recovery counter on the crystal clock.
	// It runs on the crystal's falling edge, unrelated to mclk, so its
	// done output is brought across by the synchroniser below.
	lpbr_recovery_counter u_counter
	(
		.crystal_clock (crystal_clock),
		.rstn          (rstn),
		.hold_clear    (hold_clear),
		.short_sel     (short_recovery_sel),
		.done          (rec_done)
	);

	// Counter stays cleared while stopped, released when recovery starts.
	// This level enters the crystal domain without a synchroniser. That is
	// safe: the crystal gate opens on the same mode change that drops the
	// hold, so the first falling edge sees a settled level, and a glitch
	// on the way out of recovery only clears a counter that is about to
	// be cleared anyway.
	assign hold_clear = (mode != lpbr_pkg::recover_st);

	// Bring the counter's done into the bus clock domain.
	// Two stages guard against metastability; only the second is read,
	// at the cost of two cycles added to every recovery.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rec_done_s1 <= 1'b0;
			rec_done_s2 <= 1'b0;
		end
		else
		begin
			rec_done_s1 <= rec_done;
			rec_done_s2 <= rec_done_s1;
		end
	end

	// Power mode sequencing.
	// Stop is tested before wait, so a core reporting both goes to the
	// deeper mode. Only an interrupt or a reset leaves stop, and both
	// wait and recovery return straight to run.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			mode <= lpbr_pkg::run_st;
		else
		begin
			unique case (mode)
				lpbr_pkg::run_st:
					if (stop_exec)
						mode <= lpbr_pkg::stop_st;
					else if (wait_exec)
						mode <= lpbr_pkg::wait_st;
				lpbr_pkg::wait_st:
					// Interrupt, break or reset leaves wait at once.
					if (irq_pending || break_irq || reset_req)
						mode <= lpbr_pkg::run_st;
				lpbr_pkg::stop_st:
					if (irq_pending || reset_req)
						mode <= lpbr_pkg::recover_st;
				lpbr_pkg::recover_st:
					// Clocks return only when the delay has run out.
					if (rec_done_s2 && hold_clear == 1'b0)
						mode <= lpbr_pkg::run_st;
			endcase
		end
	end

	// Either instruction unmasks interrupts.
	// The pulse passes straight through so the core sees it at once.
	assign clear_i_mask = stop_exec || wait_exec;

	// Stacking starts in the cycle an interrupt wakes wait, or once recovery ends.
	// Recovery waits for the synchronised done, so stacking comes a
	// little after the crystal delay and never before it.
	assign stack_go = ((mode == lpbr_pkg::wait_st) && irq_pending)
	               || ((mode == lpbr_pkg::recover_st) && rec_done_s2
	                   && irq_pending);

	// Break module registers are frozen through stop and recovery.
	// Decoded from the state register, so the hold never glitches.
	assign break_regs_hold = (mode == lpbr_pkg::stop_st)
	                      || (mode == lpbr_pkg::recover_st);

	// Clock gating per mode.
	// Gates follow the state register and one configuration level, so
	// they move only on mclk edges and never on a core event.
	always_comb
	begin
		clk_gate = '0;
		unique case (mode)
			lpbr_pkg::run_st:
			begin
				clk_gate.core_clk_en       = 1'b1;
				clk_gate.periph_clk_en     = 1'b1;
				clk_gate.watchdog_clk_en   = !watchdog_disable;
				clk_gate.base_clock_out_en = 1'b1;
				clk_gate.crystal_clock_en  = 1'b1;
			end
			lpbr_pkg::wait_st:
			begin
				clk_gate.periph_clk_en     = 1'b1;
				clk_gate.watchdog_clk_en   = !watchdog_disable;
				clk_gate.base_clock_out_en = 1'b1;
				clk_gate.crystal_clock_en  = 1'b1;
			end
			lpbr_pkg::stop_st:
				clk_gate = '0;
			lpbr_pkg::recover_st:
				// The oscillator runs to time recovery, the rest stays off.
				clk_gate.crystal_clock_en  = 1'b1;
		endcase
	end

	// Clearing peripheral flags is allowed outside break or with enable.
	// Protection is judged at the final access, so a first step taken
	// before break does not let the flag go while break is active; a flag
	// cleared in break is never restored on exit.
	assign flag_clear_allow = flag_clear_req
	                       && (!break_active || clr_en);

	// Write channels taken independently, committed together.
	// Neither channel is taken while a response waits, which keeps one
	// write under way at a time.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	// Each write channel is latched on its own handshake, so the master
	// may offer address and data in either order; both latches drop in
	// the cycle that commits the write.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
			w_held  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	// The response stands until the master takes it with bready.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == lpbr_pkg::break_status_off
			              || aw_addr == lpbr_pkg::reset_cause_off
			              || aw_addr == lpbr_pkg::break_ctrl_off)
			              ? 2'h0 : 2'h2;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Break clear enable register.
	// Only the low byte lane carries register bits, so only its strobe.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			clr_en <= lpbr_pkg::ctrl_reset_val[lpbr_pkg::break_clr_en_bit];
		else if (wr_fire && w_strb[0]
		         && aw_addr == lpbr_pkg::break_ctrl_off)
			clr_en <= w_data[lpbr_pkg::break_clr_en_bit];
	end

	// Break wait flag: a break during wait wins over a write of zero.
	// A reset comes first of all, since it ends any break service.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			break_wait <= 1'b0;
		else if (reset_req)
			break_wait <= 1'b0;
		else if (mode == lpbr_pkg::wait_st && break_irq)
			break_wait <= 1'b1;
		else if (wr_fire && w_strb[0]
		         && aw_addr == lpbr_pkg::break_status_off
		         && !w_data[lpbr_pkg::break_wait_bit])
			break_wait <= 1'b0;
	end

	// Read channel.
	// A new read is refused while the previous answer waits for rready.
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	// Read data selection; unmapped offsets read as zero so that a stray
	// access cannot show stale bits.
	always_comb
	begin
		rd_byte = 8'h00;
		if (s_axi_araddr == lpbr_pkg::break_status_off)
			rd_byte[lpbr_pkg::break_wait_bit] = break_wait;
		else if (s_axi_araddr == lpbr_pkg::reset_cause_off)
			rd_byte = {2'b00, cause};
		else if (s_axi_araddr == lpbr_pkg::break_ctrl_off)
			rd_byte[lpbr_pkg::break_clr_en_bit] = clr_en;
	end

	// Read answer, registered so that data and response stand unchanged
	// until the master takes them.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= (s_axi_araddr == lpbr_pkg::break_status_off
			              || s_axi_araddr == lpbr_pkg::reset_cause_off
			              || s_axi_araddr == lpbr_pkg::break_ctrl_off)
			              ? 2'h0 : 2'h2;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Reset cause register; a new reset wins over a read in the same cycle.
	// A power-on wipes every other cause; any other reset shows only its
	// own sources, and the address fault only for opcode fetches.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			cause <= '0;
		else if (reset_req)
		begin
			if (reset_src.power_on)
			begin
				cause          <= '0;
				cause.power_on <= 1'b1;
			end
			else
			begin
				cause            <= '0;
				cause.ext_pin    <= reset_src.ext_pin;
				cause.watchdog   <= reset_src.watchdog;
				cause.bad_opcode <= reset_src.bad_opcode;
				cause.bad_fetch  <= reset_src.bad_fetch
				                 && opcode_fetch;
				cause.brownout   <= reset_src.brownout;
			end
		end
		else if (rd_fire && s_axi_araddr == lpbr_pkg::reset_cause_off)
			cause <= '0;
	end

endmodule // lpbr_unit

/* File: common/lpbr_pkg.sv */
// Package with register map, field positions, reset values and structs.
package lpbr_pkg;

	// Byte addresses of the three registers on the bus.
	localparam logic [3:0] break_status_off = 4'h0;
	localparam logic [3:0] reset_cause_off  = 4'h4;
	localparam logic [3:0] break_ctrl_off   = 4'h8;

	// Field positions.
	localparam int break_wait_bit     = 1;
	localparam int break_clr_en_bit   = 7;

	// Last counter values of the two recovery lengths; done follows one
	// falling edge later, so 4096 or 32 edges pass in all.
	localparam logic [11:0] long_recovery  = 12'hfff;
	localparam logic [11:0] short_recovery = 12'h01f;

	// Reset values.
	localparam logic [7:0] ctrl_reset_val = 8'h00;

	// Power modes of the sequencer.
	typedef enum logic [1:0] {run_st, wait_st, stop_st, recover_st} mode_e;

	// Reset causes latched at a reset request.
	typedef struct packed {
		logic power_on;
		logic ext_pin;
		logic watchdog;
		logic bad_opcode;
		logic bad_fetch;
		logic brownout;
	} reset_cause_s;

	// Clock gates toward core and peripherals.
	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic watchdog_clk_en;
		logic base_clock_out_en;
		logic crystal_clock_en;
	} clk_gate_s;

endpackage

/* File: hdl/lpbr_recovery_counter.sv */
// Twelve-bit stop recovery counter clocked on the crystal falling edge.
`timescale 1ns/1ps
module lpbr_recovery_counter
(
	input  wire logic        crystal_clock,
	input  wire logic        rstn,
	input  wire logic        hold_clear,
	input  wire logic        short_sel,
	output logic             done
);
	logic [11:0] count;     // Recovery counter.
	logic        count_end; // Last count of the chosen length reached.

	// Terminal value for the selected recovery length.
	assign count_end = short_sel ? (count == lpbr_pkg::short_recovery)
	                             : (count == lpbr_pkg::long_recovery);

	// Held cleared through stop, then one step per falling edge. Done is
	// set on the edge after the last count, so a twelve-bit counter still
	// times the full 4096 edges and the short length a full 32.
	always_ff @(negedge crystal_clock or negedge rstn)
	begin
		if (!rstn)
		begin
			count <= 12'h000;
			done  <= 1'b0;
		end
		else if (hold_clear)
		begin
			count <= 12'h000;
			done  <= 1'b0;
		end
		else if (count_end)
			done <= 1'b1;
		else
			count <= count + 12'h001;
	end

endmodule // lpbr_recovery_counter

/* File: dv/lpbr_unit_monitor.sv */
// Concurrent checks on the ports of the low-power and break unit.
`timescale 1ns/1ps
module lpbr_unit_monitor
(
	input wire logic                mclk,
	input wire logic                rstn,
	input wire logic                wait_exec,
	input wire logic                stop_exec,
	input wire logic                irq_pending,
	input wire logic                break_irq,
	input wire logic                reset_req,
	input wire logic                break_active,
	input wire logic                watchdog_disable,
	input wire logic                flag_clear_req,
	input wire logic                flag_clear_allow,
	input wire logic                clear_i_mask,
	input wire logic                stack_go,
	input wire logic                break_regs_hold,
	input wire lpbr_pkg::clk_gate_s clk_gate
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Wait shows as core gated off while peripherals keep their clock.
	wire in_wait = !clk_gate.core_clk_en && clk_gate.periph_clk_en;
	// Stop shows as every gate closed.
	wire in_stop = clk_gate == 5'h00;
	a_mask_clear: assert property ((wait_exec || stop_exec) |-> clear_i_mask)
		else $error("mask not cleared");
	a_clear_normal: assert property ((flag_clear_req && !break_active)
		|-> flag_clear_allow) else $error("clear refused");
	a_stop_gates: assert property ((stop_exec && !irq_pending && !reset_req)
		|=> in_stop) else $error("stop gates");
	a_wait_gates: assert property ((wait_exec && !irq_pending && !break_irq
		&& !reset_req) |=> in_wait) else $error("wait gates");
	a_wdog_wait: assert property ((in_wait && !watchdog_disable)
		|-> clk_gate.watchdog_clk_en) else $error("watchdog");
	a_stop_hold: assert property (in_stop |-> break_regs_hold)
		else $error("break regs free");
	a_no_early: assert property (in_stop ##1 clk_gate.crystal_clock_en
		|-> !stack_go [*8]) else $error("early stack");
	a_wait_wake: assert property ((in_wait && (break_irq || reset_req))
		|=> clk_gate.core_clk_en) else $error("no wake");
	a_wake_stack: assert property ((in_wait && irq_pending) |-> stack_go)
		else $error("no stack");
endmodule // lpbr_unit_monitor

/* File: dv/lpbr_xtal_model.sv */
// Crystal oscillator model; it stands still while its gate is closed.
`timescale 1ns/1ps
module lpbr_xtal_model
(
	input  wire logic en,
	output logic      crystal_clock
);
	// Period 42 ns; its edges meet an mclk edge every 105 ns, a rising one every 210 ns.
	initial
	begin
		crystal_clock = 1'b0;
		#7;
		forever
		begin
			#21;
			if (en)
				crystal_clock = ~crystal_clock;
		end
	end
endmodule // lpbr_xtal_model

/* File: dv/tb_lpbr_unit.sv */
// Self-checking bench for the low-power and break unit.
`timescale 1ns/1ps
module tb_lpbr_unit;
	logic mclk, rstn, crystal_clock, wait_exec, stop_exec, irq_pending;
	logic break_irq, reset_req, opcode_fetch, break_active;
	logic watchdog_disable, short_recovery_sel, flag_clear_req;
	logic flag_clear_allow, clear_i_mask, stack_go, break_regs_hold;
	lpbr_pkg::reset_cause_s reset_src;
	lpbr_pkg::clk_gate_s    clk_gate;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int   error_cnt = 0; // Mismatches seen.
	int   compares  = 0; // Comparisons made.
	int   i;
	lpbr_unit lpbr_unit_i (.*);
	lpbr_xtal_model lpbr_xtal_model_i
	(
		.en            (clk_gate.crystal_clock_en),
		.crystal_clock (crystal_clock)
	);
	// Bus clock, 100 MHz.
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Prints the counts and the verdict, then ends the run.
	task stop_test;
		$display("counts: %0d compares, %0d errors", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Compares one value with its expectation.
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			$display("wrong value %s exp %h got %h", nm, e, s);
			error_cnt++;
		end
	endtask
	// One AXI4-Lite transfer; ready is looked at half a cycle before the
	// edge that takes it, since it only moves on rising edges.
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		logic pa, pw, ta, tw, tr;
		int   n;
		// Begin just after a rising edge, wherever the caller stands.
		@(posedge mclk);
		pa = 1'b1;
		pw = w;
		if (w)
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
		end
		else
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
		end
		for (n = 0; n < 60; n++)
		begin
			@(negedge mclk);
			ta = w ? s_axi_awready : s_axi_arready;
			tw = s_axi_wready;
			tr = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge mclk);
			if (ta && pa)
			begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (tw && pw)
			begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (tr)
				break;
		end
		if (n == 60)
		begin
			error_cnt++;
			stop_test();
		end
	endtask
	// Register read with expected data and response.
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 8'h00, q, r);
		chk("rdata", e, q);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	// Register write expecting an OKAY response.
	task wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
		chk("bresp", 32'h0, {30'h0, r});
	endtask
	// One reset event with its cause vector.
	task cause(input logic [5:0] s, input logic f);
		@(posedge mclk);
		reset_src <= lpbr_pkg::reset_cause_s'(s);
		opcode_fetch <= f;
		reset_req <= 1'b1;
		@(posedge mclk);
		reset_req <= 1'b0;
	endtask
	// Enters wait and lets a break end it.
	task wait_break;
		@(posedge mclk);
		wait_exec <= 1'b1;
		@(posedge mclk);
		wait_exec <= 1'b0;
		break_irq <= 1'b1;
		@(posedge mclk);
		break_irq <= 1'b0;
	endtask
	// Stop, interrupt, then count cycles until the core may stack.
	task stop_run(input logic sh, input int lo, input int hi);
		int n;
		@(posedge mclk);
		short_recovery_sel <= sh;
		stop_exec <= 1'b1;
		@(posedge mclk);
		stop_exec <= 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("gates", 32'h0, {27'h0, clk_gate});
		chk("hold", 32'h1, {31'h0, break_regs_hold});
		@(posedge mclk);
		irq_pending <= 1'b1;
		for (n = 0; n < hi && stack_go !== 1'b1; n++)
			@(negedge mclk);
		chk("recovery", 32'h1, {31'h0, n >= lo && n < hi});
		if (n >= hi)
			stop_test();
		@(posedge mclk);
		irq_pending <= 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("core", 32'h1, {31'h0, clk_gate.core_clk_en});
		chk("run gates", 32'h1f, {27'h0, clk_gate});
		chk("hold", 32'h0, {31'h0, break_regs_hold});
		$display("test stop recovery done");
	endtask
	// Main sequence.
	initial
	begin
		{rstn, wait_exec, stop_exec, irq_pending, break_irq} = 5'h00;
		{reset_req, opcode_fetch, break_active, flag_clear_req} = 4'h0;
		{watchdog_disable, short_recovery_sel} = 2'h0;
		reset_src = lpbr_pkg::reset_cause_s'(6'h00);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		// Always ready for answers, which the bus permits.
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h8, 32'h0, 2'h0);
		rd(4'hc, 32'h0, 2'h2);
		cause(6'h10, 1'b0);
		cause(6'h20, 1'b0);
		rd(4'h4, 32'h20, 2'h0);
		for (i = 0; i < 6; i++)
		begin
			cause(6'h01 << i, 1'b1);
			rd(4'h4, 32'h1 << i, 2'h0);
			rd(4'h4, 32'h0, 2'h0);
		end
		cause(6'h02, 1'b0);
		rd(4'h4, 32'h0, 2'h0);
		$display("test reset cause done");
		@(posedge mclk);
		break_active <= 1'b1;
		flag_clear_req <= 1'b1;
		@(negedge mclk);
		chk("allow", 32'h0, {31'h0, flag_clear_allow});
		wr(4'h8, 8'h80);
		rd(4'h8, 32'h80, 2'h0);
		@(negedge mclk);
		chk("allow", 32'h1, {31'h0, flag_clear_allow});
		wr(4'h8, 8'h00);
		@(negedge mclk);
		chk("allow", 32'h0, {31'h0, flag_clear_allow});
		@(posedge mclk);
		break_active <= 1'b0;
		@(negedge mclk);
		chk("allow", 32'h1, {31'h0, flag_clear_allow});
		$display("test break protection done");
		@(posedge mclk);
		wait_exec <= 1'b1;
		@(negedge mclk);
		chk("mask", 32'h1, {31'h0, clear_i_mask});
		@(posedge mclk);
		wait_exec <= 1'b0;
		@(negedge mclk);
		chk("core", 32'h0, {31'h0, clk_gate.core_clk_en});
		chk("periph", 32'h1, {31'h0, clk_gate.periph_clk_en});
		chk("wdog", 32'h1, {31'h0, clk_gate.watchdog_clk_en});
		chk("base", 32'h1, {31'h0, clk_gate.base_clock_out_en});
		@(posedge mclk);
		watchdog_disable <= 1'b1;
		@(negedge mclk);
		chk("wdog", 32'h0, {31'h0, clk_gate.watchdog_clk_en});
		@(posedge mclk);
		watchdog_disable <= 1'b0;
		break_irq <= 1'b1;
		@(posedge mclk);
		break_irq <= 1'b0;
		rd(4'h0, 32'h2, 2'h0);
		wr(4'h0, 8'h00);
		rd(4'h0, 32'h0, 2'h0);
		wait_break();
		rd(4'h0, 32'h2, 2'h0);
		cause(6'h10, 1'b0);
		rd(4'h0, 32'h0, 2'h0);
		@(posedge mclk);
		wait_exec <= 1'b1;
		@(posedge mclk);
		wait_exec <= 1'b0;
		irq_pending <= 1'b1;
		@(negedge mclk);
		chk("stack", 32'h1, {31'h0, stack_go});
		@(posedge mclk);
		irq_pending <= 1'b0;
		$display("test wait done");
		stop_run(1'b1, 128, 180);
		stop_run(1'b0, 17190, 17400);
		stop_test();
	end
endmodule // tb_lpbr_unit
bind lpbr_unit lpbr_unit_monitor lpbr_unit_monitor_i (.*);
